// [hw/imc_top.sv]
// Direct input mapping, channel drive and sleep or limp-home mode control
// What this block does
// - By default input a drives channel 2, input b drives channel 3.
// - Each input has its own programmable channel map register.
// - Channel drive is OR of output control bit and mapped inputs.
// - Input pin levels are readable in the input status monitor.
// - The input status monitor keeps tracking in limp-home mode.
// - Sleep pin low with any input high gives limp-home, default channels only.
// - Sleep pin low with all inputs low gives sleep mode.
// - While sleep pin is low, serial registers hold their defaults.
// - In sleep mode the undervoltage detector is disabled.
// - In sleep mode serial transfers are ignored and serial output floats.
`timescale 1ns/1ps
`default_nettype none
module imc_top #(
   parameter int NCH = imc_pkg::NUM_CH
) (
   input  wire logic                       clk,
   input  wire logic                       sys_rst,
   input  wire logic                       direct_input_a,
   input  wire logic                       direct_input_b,
   input  wire logic                       sleep_ctrl,
   input  wire logic [imc_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]                 reg_wdata,
   input  wire logic                       reg_wr,
   input  wire logic                       reg_rd,
   output logic      [7:0]                 reg_rdata,
   output logic      [NCH-1:0]             channel_drive,
   output logic      [1:0]                 op_mode,
   output logic                            uv_detect_en,
   output logic                            serial_enable,
   output logic                            so_oe
);
   import imc_pkg::*;

   logic [2:0]     sync_a_r;
   logic [2:0]     sync_b_r;
   logic [2:0]     sync_s_r;
   logic           in_a_r;
   logic           in_b_r;
   logic           idle_r;
   logic [NCH-1:0] out_ctrl_r;
   logic [NCH-1:0] map_a_r;
   logic [NCH-1:0] map_b_r;
   logic [NCH-1:0] drive_nxt;
   logic [NCH-1:0] def_a;
   logic [NCH-1:0] def_b;
   imc_mode_t      mode_r;
   imc_mode_t      mode_nxt;
   logic [7:0]     rdata_nxt;

   // Three-stage pin synchronisers; a level counts once stages two and three agree
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sync_a_r <= 3'h0;
         sync_b_r <= 3'h0;
         sync_s_r <= 3'h0;
      end else begin
         sync_a_r <= {sync_a_r[1:0], direct_input_a};
         sync_b_r <= {sync_b_r[1:0], direct_input_b};
         sync_s_r <= {sync_s_r[1:0], sleep_ctrl};
      end
   end

   // Filtered levels, updated only when the last two stages agree
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         in_a_r <= 1'b0;
         in_b_r <= 1'b0;
         idle_r <= 1'b0;
      end else begin
         if (sync_a_r[1] == sync_a_r[2]) in_a_r <= sync_a_r[2];
         if (sync_b_r[1] == sync_b_r[2]) in_b_r <= sync_b_r[2];
         if (sync_s_r[1] == sync_s_r[2]) idle_r <= sync_s_r[2];
      end
   end

   // Mode decision from sleep pin and inputs
   always_comb begin
      if (idle_r) begin
         mode_nxt = IMC_NORMAL;
      end else if (in_a_r || in_b_r) begin
         mode_nxt = IMC_LIMP;
      end else begin
         mode_nxt = IMC_SLEEP;
      end
   end

   // Mode register; starts in sleep until the pins are seen
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_r <= IMC_SLEEP;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Serial registers, held at defaults while the sleep pin is low
   always_ff @(posedge clk) begin
      if (sys_rst || !idle_r) begin
         out_ctrl_r <= NCH'(OUT_CTRL_RST);
         map_a_r    <= NCH'(MAP_A_RST);
         map_b_r    <= NCH'(MAP_B_RST);
      end else if (reg_wr) begin
         if (reg_addr == OFS_OUT_CTRL) begin
            out_ctrl_r <= reg_wdata[NCH-1:0];
         end else if (reg_addr == OFS_MAP_A) begin
            map_a_r <= reg_wdata[NCH-1:0];
         end else if (reg_addr == OFS_MAP_B) begin
            map_b_r <= reg_wdata[NCH-1:0];
         end
      end
   end

   // Default channel masks
   always_comb begin
      def_a = '0;
      def_b = '0;
      def_a[DEF_CH_A] = 1'b1;
      def_b[DEF_CH_B] = 1'b1;
   end

   // Per-channel drive: register bit OR mapped inputs; limp-home uses defaults only
   for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
      always_comb begin
         if (mode_r == IMC_NORMAL) begin
            drive_nxt[ch] = out_ctrl_r[ch] | (in_a_r & map_a_r[ch]) | (in_b_r & map_b_r[ch]);
         end else if (mode_r == IMC_LIMP) begin
            drive_nxt[ch] = (in_a_r & def_a[ch]) | (in_b_r & def_b[ch]);
         end else begin
            drive_nxt[ch] = 1'b0;
         end
      end
   end

   // Channel drive outputs from flip-flops
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         channel_drive <= '0;
      end else begin
         channel_drive <= drive_nxt;
      end
   end

   // Read mux; serial reads ignored in sleep, unmapped reads give zero
   always_comb begin
      rdata_nxt = 8'h00;
      if (mode_r == IMC_SLEEP) begin
         rdata_nxt = 8'h00;
      end else if (reg_addr == OFS_OUT_CTRL) begin
         rdata_nxt[NCH-1:0] = out_ctrl_r;
      end else if (reg_addr == OFS_MAP_A) begin
         rdata_nxt[NCH-1:0] = map_a_r;
      end else if (reg_addr == OFS_MAP_B) begin
         rdata_nxt[NCH-1:0] = map_b_r;
      end else if (reg_addr == OFS_IN_STAT) begin
         rdata_nxt[STAT_A_BIT] = in_a_r;
         rdata_nxt[STAT_B_BIT] = in_b_r;
      end else if (reg_addr == OFS_MODE) begin
         rdata_nxt[1:0] = mode_r;
      end
   end

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // Status outputs tied to the mode
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         op_mode       <= IMC_SLEEP;
         uv_detect_en  <= 1'b0;
         serial_enable <= 1'b0;
      end else begin
         op_mode       <= mode_nxt;
         uv_detect_en  <= (mode_nxt != IMC_SLEEP);
         serial_enable <= (mode_nxt != IMC_SLEEP);
      end
   end

   // Serial output enable, only while the serial side is live
   assign so_oe = serial_enable & reg_rd;

   // Assertions
   sequence s_limp_entry;
      !idle_r && (in_a_r || in_b_r);
   endsequence

   a_limp_default_only: assert property (@(posedge clk) disable iff (sys_rst)
      s_limp_entry ##1 (mode_r == IMC_LIMP) |=>
         (channel_drive[DEF_CH_A] == $past(in_a_r)) && (channel_drive[DEF_CH_B] == $past(in_b_r)))
      else $error("limp-home drive wrong");
   a_sleep_entry: assert property (@(posedge clk) disable iff (sys_rst)
      (!idle_r && !in_a_r && !in_b_r) |=> (mode_r == IMC_SLEEP))
      else $error("sleep mode not entered");
   a_regs_default: assert property (@(posedge clk) disable iff (sys_rst)
      !idle_r |=> (out_ctrl_r == NCH'(OUT_CTRL_RST)) && (map_a_r == NCH'(MAP_A_RST)))
      else $error("registers not held at default");
   a_uv_off_sleep: assert property (@(posedge clk) disable iff (sys_rst)
      (mode_nxt == IMC_SLEEP) |=> !uv_detect_en)
      else $error("undervoltage detect on in sleep");
   a_so_float_sleep: assert property (@(posedge clk) disable iff (sys_rst)
      (mode_r == IMC_SLEEP) |-> !so_oe ##1 (reg_rdata == 8'h00))
      else $error("serial output active in sleep");
   a_drive_or: assert property (@(posedge clk) disable iff (sys_rst)
      (mode_r == IMC_NORMAL) |=> (channel_drive == $past(out_ctrl_r | ({NCH{in_a_r}} & map_a_r)
         | ({NCH{in_b_r}} & map_b_r))))
      else $error("channel drive not OR of sources");
   a_status_track: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_rd && reg_addr == OFS_IN_STAT && mode_r != IMC_SLEEP) |=>
         (reg_rdata[1:0] == {$past(in_b_r), $past(in_a_r)}))
      else $error("input status wrong");
   a_sync_filter: assert property (@(posedge clk) disable iff (sys_rst)
      (sync_a_r[2] != sync_a_r[1]) |=> (in_a_r == $past(in_a_r)))
      else $error("input changed before stages agreed");
   a_map_write: assert property (@(posedge clk) disable iff (sys_rst)
      (idle_r && reg_wr && reg_addr == OFS_MAP_B) ##1 idle_r |-> (map_b_r == $past(reg_wdata[NCH-1:0])))
      else $error("map write lost");

   // Filter steps per pin: once stages two and three agree, the filtered level follows stage three
   // A glitch that reaches stage two for one cycle never gets past the filter
   sequence s_a_agree;
      sync_a_r[1] == sync_a_r[2];
   endsequence
   sequence s_b_agree;
      sync_b_r[1] == sync_b_r[2];
   endsequence
   sequence s_s_agree;
      sync_s_r[1] == sync_s_r[2];
   endsequence

   a_sync_adopt_a: assert property (@(posedge clk) disable iff (sys_rst)
      s_a_agree |=> (in_a_r == $past(sync_a_r[2])))
      else $error("input a not adopted after stages agreed");
   a_sync_adopt_b: assert property (@(posedge clk) disable iff (sys_rst)
      s_b_agree |=> (in_b_r == $past(sync_b_r[2])))
      else $error("input b not adopted after stages agreed");
   a_sync_adopt_s: assert property (@(posedge clk) disable iff (sys_rst)
      s_s_agree |=> (idle_r == $past(sync_s_r[2])))
      else $error("sleep pin not adopted after stages agreed");
   a_sync_hold_b: assert property (@(posedge clk) disable iff (sys_rst)
      (sync_b_r[2] != sync_b_r[1]) |=> (in_b_r == $past(in_b_r)))
      else $error("input b changed before stages agreed");
   a_sync_hold_s: assert property (@(posedge clk) disable iff (sys_rst)
      (sync_s_r[2] != sync_s_r[1]) |=> (idle_r == $past(idle_r)))
      else $error("sleep pin changed before stages agreed");

   // Sleep steps: request seen on two edges in a row, then drive, supervision and serial side go quiet
   // Two edges, so the check starts only once the registered mode has caught up with the request
   sequence s_sleep_req;
      !idle_r && !in_a_r && !in_b_r;
   endsequence
   sequence s_sleep_held;
      s_sleep_req ##1 s_sleep_req;
   endsequence

   a_op_mode_sleep: assert property (@(posedge clk) disable iff (sys_rst)
      s_sleep_req |=> (op_mode == IMC_SLEEP))
      else $error("mode output not sleep");
   a_sleep_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      s_sleep_held |=> (channel_drive == '0))
      else $error("channel driven in sleep");
   a_uv_off_held: assert property (@(posedge clk) disable iff (sys_rst)
      s_sleep_held |=> !uv_detect_en)
      else $error("undervoltage detect on during held sleep");
   a_serial_off_held: assert property (@(posedge clk) disable iff (sys_rst)
      s_sleep_held |=> !serial_enable && !so_oe)
      else $error("serial side live during held sleep");
   a_read_sleep_zero: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_rd && (mode_r == IMC_SLEEP)) |=> (reg_rdata == 8'h00))
      else $error("read answered in sleep");

   // Wake steps: sleep pin seen high, then normal mode with supervision and serial side live
   sequence s_wake;
      idle_r;
   endsequence

   a_wake_normal: assert property (@(posedge clk) disable iff (sys_rst)
      s_wake |=> (mode_r == IMC_NORMAL) && (op_mode == IMC_NORMAL))
      else $error("normal mode not entered");
   a_wake_serial_on: assert property (@(posedge clk) disable iff (sys_rst)
      s_wake |=> serial_enable && uv_detect_en)
      else $error("serial side or supervision off while awake");

   // Limp-home steps: programmed maps and output control must not leak onto the channels
   sequence s_rd_status_limp;
      reg_rd && (reg_addr == OFS_IN_STAT) && (mode_r == IMC_LIMP);
   endsequence

   a_limp_mode_out: assert property (@(posedge clk) disable iff (sys_rst)
      s_limp_entry |=> (op_mode == IMC_LIMP) && serial_enable && uv_detect_en)
      else $error("limp-home mode outputs wrong");
   a_limp_others_off: assert property (@(posedge clk) disable iff (sys_rst)
      (mode_r == IMC_LIMP) |=> ((channel_drive & ~(def_a | def_b)) == '0))
      else $error("non-default channel driven in limp-home");
   a_limp_quiet: assert property (@(posedge clk) disable iff (sys_rst)
      ((mode_r == IMC_LIMP) && !in_a_r && !in_b_r) |=> (channel_drive == '0))
      else $error("channel driven in limp-home with inputs low");
   a_status_limp: assert property (@(posedge clk) disable iff (sys_rst)
      s_rd_status_limp |=> (reg_rdata[STAT_A_BIT] == $past(in_a_r))
         && (reg_rdata[STAT_B_BIT] == $past(in_b_r)))
      else $error("input status not tracked in limp-home");
   a_mode_read: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_rd && (reg_addr == OFS_MODE) && (mode_r != IMC_SLEEP)) |=> (reg_rdata[1:0] == $past(mode_r)))
      else $error("mode readback wrong");

   // Register steps: a write while awake lands on the next edge; a low sleep pin restores defaults
   sequence s_wr_map_a;
      idle_r && reg_wr && (reg_addr == OFS_MAP_A);
   endsequence
   sequence s_wr_out_ctrl;
      idle_r && reg_wr && (reg_addr == OFS_OUT_CTRL);
   endsequence

   a_map_a_write: assert property (@(posedge clk) disable iff (sys_rst)
      s_wr_map_a |=> (map_a_r == $past(reg_wdata[NCH-1:0])))
      else $error("map a write lost");
   a_out_ctrl_write: assert property (@(posedge clk) disable iff (sys_rst)
      s_wr_out_ctrl |=> (out_ctrl_r == $past(reg_wdata[NCH-1:0])))
      else $error("output control write lost");
   a_map_b_default: assert property (@(posedge clk) disable iff (sys_rst)
      !idle_r |=> (map_b_r == NCH'(MAP_B_RST)))
      else $error("map b not held at default");
   a_ctrl_blocked_low: assert property (@(posedge clk) disable iff (sys_rst)
      (!idle_r && reg_wr) |=> (out_ctrl_r == NCH'(OUT_CTRL_RST)))
      else $error("write taken while sleep pin low");
   a_default_on_wake: assert property (@(posedge clk) disable iff (sys_rst)
      $rose(idle_r) |-> (map_a_r == NCH'(MAP_A_RST)) && (map_b_r == NCH'(MAP_B_RST)))
      else $error("default channel maps not restored");

   // Read port: data stands only in the cycle after the strobe, zero otherwise
   a_rdata_one_cycle: assert property (@(posedge clk) disable iff (sys_rst)
      !reg_rd |=> (reg_rdata == 8'h00))
      else $error("read data outside its cycle");
endmodule
`default_nettype wire

// [hw/imc_pkg.sv]
// Constants for the input mapping and mode control block
package imc_pkg;
   localparam int          NUM_CH        = 8;
   localparam int          ADDR_W        = 4;
   // Register offsets
   localparam logic [3:0]  OFS_OUT_CTRL  = 4'h0;
   localparam logic [3:0]  OFS_MAP_A     = 4'h1;
   localparam logic [3:0]  OFS_MAP_B     = 4'h2;
   localparam logic [3:0]  OFS_IN_STAT   = 4'h3;
   localparam logic [3:0]  OFS_MODE      = 4'h4;
   // Default channels of the direct inputs
   localparam int          DEF_CH_A      = 2;
   localparam int          DEF_CH_B      = 3;
   // Reset values
   localparam logic [7:0]  OUT_CTRL_RST  = 8'h00;
   localparam logic [7:0]  MAP_A_RST     = 8'h04;
   localparam logic [7:0]  MAP_B_RST     = 8'h08;
   // Input status field positions
   localparam int          STAT_A_BIT    = 0;
   localparam int          STAT_B_BIT    = 1;
   // Operating modes
   typedef enum logic [1:0] {
      IMC_NORMAL,
      IMC_LIMP,
      IMC_SLEEP
   } imc_mode_t;
endpackage

// [verif/imc_host_model.sv]
// Host model that drives the direct input pins and the sleep pin
`timescale 1ns/1ps
`default_nettype none
module imc_host_model #(
   parameter int MIN_HOLD = 4
) (
   input  wire logic clk,
   input  wire logic want_a,
   input  wire logic want_b,
   input  wire logic want_sleep_ctrl,
   output var logic  pin_a,
   output var logic  pin_b,
   output var logic  pin_sleep
);
   int unsigned held = 0;
   // Pins start with inputs low and the sleep pin high
   initial begin
      pin_a = 1'b0;
      pin_b = 1'b0;
      pin_sleep = 1'b1;
   end
   // Sleep pin moves only after its level has been held long enough
   always @(posedge clk) begin
      pin_a <= want_a;
      pin_b <= want_b;
      held <= held + 1;
      if (want_sleep_ctrl !== pin_sleep && held >= MIN_HOLD) begin
         pin_sleep <= want_sleep_ctrl;
         held <= 0;
      end
   end
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the input mapping and mode control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
   $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module tb;
   import imc_pkg::*;
   logic       clk, sys_rst, want_a, want_b, want_slp, pin_a, pin_b, pin_slp;
   logic       reg_wr, reg_rd, uv_detect_en, serial_enable, so_oe, oe_seen;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, channel_drive, rd;
   logic [1:0] op_mode;
   int         bad_count = 0, compares = 0, cycles = 0;
   imc_top imc_top_i (.clk(clk), .sys_rst(sys_rst), .direct_input_a(pin_a), .direct_input_b(pin_b),
      .sleep_ctrl(pin_slp), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .channel_drive(channel_drive), .op_mode(op_mode), .uv_detect_en(uv_detect_en),
      .serial_enable(serial_enable), .so_oe(so_oe));
   imc_host_model imc_host_model_i (.clk(clk), .want_a(want_a), .want_b(want_b), .want_sleep_ctrl(want_slp),
      .pin_a(pin_a), .pin_b(pin_b), .pin_sleep(pin_slp));
   // Clock at 25 ns period
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // Verdict and end of run
   task automatic finish_test();
      if (bad_count == 0 && compares > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         bad_count++;
         finish_test();
      end
   end
   // One-cycle register write
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // One-cycle read, data taken in the following cycle
   task automatic rdx(input logic [3:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      #1 oe_seen = so_oe;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd = reg_rdata;
   endtask
   // Ask the host for new pin levels and let them settle
   task automatic pins(input logic a, input logic b, input logic s);
      want_a <= a;
      want_b <= b;
      want_slp <= s;
      repeat (14) @(posedge clk);
      #1;
   endtask
   task automatic t_defaults();
      pins(0, 0, 1);
      rdx(OFS_MAP_A); `CHK(rd, MAP_A_RST)
      rdx(OFS_MAP_B); `CHK(rd, MAP_B_RST)
      rdx(OFS_OUT_CTRL); `CHK(rd, OUT_CTRL_RST)
      `CHK(op_mode, IMC_NORMAL)
      rdx(OFS_MODE); `CHK(rd, {6'h00, IMC_NORMAL})
   endtask
   task automatic t_mapping();
      pins(1, 0, 1); `CHK(channel_drive, 8'h04)
      pins(0, 1, 1); `CHK(channel_drive, 8'h08)
      wr(OFS_OUT_CTRL, 8'h81);
      wr(OFS_MAP_A, 8'h30);
      pins(1, 1, 1); `CHK(channel_drive, 8'hb9)
      pins(1, 0, 1); `CHK(channel_drive, 8'hb1)
      rdx(OFS_IN_STAT); `CHK(rd, 8'h01)
      pins(0, 1, 1);
      rdx(OFS_IN_STAT); `CHK(rd, 8'h02)
      rdx(4'hf); `CHK(rd, 8'h00)
   endtask
   task automatic t_limp();
      pins(1, 0, 0); `CHK(op_mode, IMC_LIMP)
      `CHK(channel_drive, 8'h04)
      rdx(OFS_IN_STAT); `CHK(rd, 8'h01)
      rdx(OFS_MAP_A); `CHK(rd, MAP_A_RST)
      wr(OFS_OUT_CTRL, 8'hff);
      rdx(OFS_OUT_CTRL); `CHK(rd, OUT_CTRL_RST)
      rdx(OFS_MODE); `CHK(rd, {6'h00, IMC_LIMP})
      pins(1, 1, 0); `CHK(channel_drive, 8'h0c)
   endtask
   task automatic t_sleep();
      pins(0, 0, 0); `CHK(op_mode, IMC_SLEEP)
      `CHK(uv_detect_en, 1'b0)
      `CHK(serial_enable, 1'b0)
      `CHK(channel_drive, 8'h00)
      rdx(OFS_MAP_B); `CHK(rd, 8'h00)
      `CHK(oe_seen, 1'b0)
      pins(0, 0, 1); `CHK(uv_detect_en, 1'b1)
      rdx(OFS_OUT_CTRL); `CHK(rd, OUT_CTRL_RST)
      `CHK(oe_seen, 1'b1)
   endtask
   // Mid-run reset: outputs clear during reset, registers back to defaults after it
   task automatic t_reset();
      pins(1, 0, 1); `CHK(channel_drive, 8'h04)
      wr(OFS_MAP_B, 8'h40);
      rdx(OFS_MAP_B); `CHK(rd, 8'h40)
      @(posedge clk);
      sys_rst <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      `CHK(channel_drive, 8'h00)
      `CHK(op_mode, IMC_SLEEP)
      `CHK(uv_detect_en, 1'b0)
      @(posedge clk);
      sys_rst <= 1'b0;
      pins(1, 0, 1); `CHK(channel_drive, 8'h04)
      rdx(OFS_MAP_B); `CHK(rd, MAP_B_RST)
   endtask
   // Reset for ten cycles, then run each scenario
   initial begin
      sys_rst = 1'b1;
      want_a = 1'b0;
      want_b = 1'b0;
      want_slp = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      t_defaults();
      t_mapping();
      t_limp();
      t_sleep();
      t_reset();
      finish_test();
   end
endmodule
`default_nettype wire
